// File: trsc_pkg.sv
// Constants and types for the timing reference state control block
// Operation
// - Primary loop walks its states without software
// - Locked only once a reference is validated
// - Locked loop averages frequency for holdover use
// - Selected reference failure quickly forces holdover
// - Holdover moves on to next valid reference
// - Switching is revertive or nonrevertive by choice
// - All references lost keeps loop in holdover
// - Monitor checks fourteen inputs: activity and frequency
// - Separate priority tables pick each loop's best
// - Selected reference can divide down to 8kHz
// - Lock at 8kHz to Nx8kHz up to 155.52MHz
// - Local oscillator times sixteen gives master clock
// - Watchdog flags local oscillator failure to processor
// - Secondary loop measures frequency or phase difference
// - Master and slave devices select identical primary references
package trsc_pkg;
    // Input references and selection
    localparam int NUM_REF = 14;
    localparam int IDX_W = 4;
    localparam int NSEL = 16;
    localparam int PRI_W = 4;
    localparam logic [3:0] PRI_OFF = 4'h0;
    // Counters and data widths
    localparam int CNT_W = 24;
    localparam int FREQ_W = 32;
    localparam int DIV_W = 15;
    localparam int QUAL_W = 2;
    localparam logic [1:0] QUAL_MAX = 2'h3;
    localparam int HOLD_SHIFT = 8;
    // Timing: clock rate and times in their own units
    localparam int CLK_MHZ = 100;
    localparam int GATE_US = 1000;
    localparam int ACT_US = 250;
    localparam int WDT_NS = 200;
    localparam int WDT_CYC = (WDT_NS * CLK_MHZ + 999) / 1000;
    // Master clock multiplication factor
    localparam logic [4:0] MCLK_MULT = 5'h10;
    localparam int MTIME_W = 32;
    // Primary loop states
    typedef enum logic [1:0] {
        TRSC_FREE_RUN,
        TRSC_LOCKED,
        TRSC_HOLDOVER
    } trsc_state_t;
endpackage

// File: trsc_timing_ctrl.sv
// Reference monitor, selector and primary loop state control
`timescale 1ns/100ps
module trsc_timing_ctrl #(
    parameter int GATE_CYC = trsc_pkg::GATE_US * trsc_pkg::CLK_MHZ,
    parameter int ACT_CYC = trsc_pkg::ACT_US * trsc_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Reference clock pins and monitor setup
    input wire logic [trsc_pkg::NUM_REF-1:0] ref_in,
    input wire logic [trsc_pkg::NUM_REF*trsc_pkg::CNT_W-1:0] exp_cnt,
    input wire logic [trsc_pkg::CNT_W-1:0] freq_tol,
    // Priority tables and switching mode
    input wire logic [trsc_pkg::NUM_REF*trsc_pkg::PRI_W-1:0] pri_primary,
    input wire logic [trsc_pkg::NUM_REF*trsc_pkg::PRI_W-1:0] pri_secondary,
    input wire logic revertive,
    // Divide ratios to 8kHz
    input wire logic [trsc_pkg::DIV_W-1:0] div_primary,
    input wire logic [trsc_pkg::DIV_W-1:0] div_secondary,
    // Loop filter frequency word
    input wire logic [trsc_pkg::FREQ_W-1:0] primary_freq_in,
    // Secondary loop measurement setup
    input wire logic meas_phase_mode,
    input wire logic [trsc_pkg::IDX_W-1:0] meas_ref_a,
    input wire logic [trsc_pkg::IDX_W-1:0] meas_ref_b,
    // Redundancy pins
    input wire logic slave_mode,
    input wire logic [trsc_pkg::IDX_W-1:0] master_sel_in,
    input wire logic master_sel_vld_in,
    // Local oscillator
    input wire logic local_osc_clock,
    // Reference status and selections
    output logic [trsc_pkg::NUM_REF-1:0] ref_valid_q,
    output logic [trsc_pkg::IDX_W-1:0] pri_sel_q,
    output logic pri_sel_vld_q,
    output logic [trsc_pkg::IDX_W-1:0] sec_sel_q,
    output logic sec_sel_vld_q,
    // Primary loop state and frequency
    output trsc_pkg::trsc_state_t state_q,
    output logic [trsc_pkg::FREQ_W-1:0] out_freq_q,
    output logic [trsc_pkg::FREQ_W-1:0] hold_freq_q,
    // 8kHz divided references
    output logic pri_8k_q,
    output logic sec_8k_q,
    // Measurement result
    output logic [trsc_pkg::CNT_W-1:0] meas_q,
    output logic meas_vld_q,
    // Oscillator health and master time
    output logic osc_fail_q,
    output logic [trsc_pkg::MTIME_W-1:0] master_time_q
);
    localparam logic [trsc_pkg::CNT_W-1:0] GATE_LAST = trsc_pkg::CNT_W'(GATE_CYC - 1);
    localparam logic [trsc_pkg::CNT_W-1:0] ACT_LIM = trsc_pkg::CNT_W'(ACT_CYC);
    localparam logic [trsc_pkg::CNT_W-1:0] WDT_LIM = trsc_pkg::CNT_W'(trsc_pkg::WDT_CYC);

    // Best valid reference from a table; ties go to the lower input
    function automatic logic [trsc_pkg::IDX_W:0] pick(
        input logic [trsc_pkg::NUM_REF-1:0] v,
        input logic [trsc_pkg::NUM_REF*trsc_pkg::PRI_W-1:0] p
    );
        logic found;
        logic [trsc_pkg::IDX_W-1:0] idx;
        logic [trsc_pkg::PRI_W-1:0] bp;
        found = 1'b0;
        idx = '0;
        bp = '0;
        for (int i = 0; i < trsc_pkg::NUM_REF; i++) begin
            if (v[i] && p[i*trsc_pkg::PRI_W +: trsc_pkg::PRI_W] != trsc_pkg::PRI_OFF &&
                (!found || p[i*trsc_pkg::PRI_W +: trsc_pkg::PRI_W] < bp)) begin
                found = 1'b1;
                idx = trsc_pkg::IDX_W'(i);
                bp = p[i*trsc_pkg::PRI_W +: trsc_pkg::PRI_W];
            end
        end
        return {found, idx};
    endfunction
    // Magnitude of a count difference
    function automatic logic [trsc_pkg::CNT_W-1:0] absdiff(
        input logic [trsc_pkg::CNT_W-1:0] a,
        input logic [trsc_pkg::CNT_W-1:0] b
    );
        return (a > b) ? a - b : b - a;
    endfunction
    logic [trsc_pkg::NUM_REF-1:0] ref_s1_q, ref_s2_q, ref_s3_q;
    logic [trsc_pkg::NUM_REF-1:0] rise;
    logic [trsc_pkg::NSEL-1:0] rise_pad, valid_pad;
    logic [2:0] osc_s_q;
    logic [trsc_pkg::IDX_W:0] msel_s1_q, msel_s2_q;
    logic [trsc_pkg::CNT_W-1:0] gate_cnt_q;
    logic gate_end;
    logic [trsc_pkg::CNT_W-1:0] act_cnt_q [trsc_pkg::NUM_REF];
    logic [trsc_pkg::CNT_W-1:0] edge_cnt_q [trsc_pkg::NUM_REF];
    logic [trsc_pkg::QUAL_W-1:0] qual_q [trsc_pkg::NUM_REF];
    logic [trsc_pkg::IDX_W:0] pri_cand, sec_cand;
    logic [trsc_pkg::IDX_W-1:0] pri_sel_d;
    logic pri_sel_vld_d;
    logic [trsc_pkg::DIV_W-1:0] div_cnt_q [2];
    logic [1:0] sel_rise;
    logic [trsc_pkg::DIV_W-1:0] div_ratio [2];
    logic ph_run_q;
    logic [trsc_pkg::CNT_W-1:0] ph_cnt_q;
    logic [trsc_pkg::CNT_W-1:0] wdt_cnt_q;
    logic osc_rise;
    // Two flops before any logic looks at the pins; third flop for edges
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_s1_q <= '0;
            ref_s2_q <= '0;
            ref_s3_q <= '0;
            osc_s_q <= '0;
            msel_s1_q <= '0;
            msel_s2_q <= '0;
        end else begin
            ref_s1_q <= ref_in;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            osc_s_q <= {osc_s_q[1:0], local_osc_clock};
            msel_s1_q <= {master_sel_vld_in, master_sel_in};
            msel_s2_q <= msel_s1_q;
        end
    end
    // Edge strobes; padded so an out-of-range index reads as idle
    assign rise = ref_s2_q & ~ref_s3_q;
    assign rise_pad = {{(trsc_pkg::NSEL - trsc_pkg::NUM_REF){1'b0}}, rise};
    assign valid_pad = {{(trsc_pkg::NSEL - trsc_pkg::NUM_REF){1'b0}}, ref_valid_q};
    assign osc_rise = osc_s_q[1] & ~osc_s_q[2];
    assign gate_end = (gate_cnt_q == GATE_LAST);
    // Shared frequency gate window
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_cnt_q <= '0;
        end else if (gate_end) begin
            gate_cnt_q <= '0;
        end else begin
            gate_cnt_q <= gate_cnt_q + 1'b1;
        end
    end
    // Activity and frequency monitors on every input
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < trsc_pkg::NUM_REF; i++) begin
                act_cnt_q[i] <= '0;
                edge_cnt_q[i] <= '0;
                qual_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < trsc_pkg::NUM_REF; i++) begin
                if (rise[i]) begin
                    act_cnt_q[i] <= '0;
                end else if (act_cnt_q[i] != ACT_LIM) begin
                    act_cnt_q[i] <= act_cnt_q[i] + 1'b1;
                end
                if (gate_end) begin
                    edge_cnt_q[i] <= trsc_pkg::CNT_W'(rise[i]);
                    // A reference must pass several windows in a row
                    if (absdiff(edge_cnt_q[i], exp_cnt[i*trsc_pkg::CNT_W +: trsc_pkg::CNT_W])
                        > freq_tol || act_cnt_q[i] == ACT_LIM) begin
                        qual_q[i] <= '0;
                    end else if (qual_q[i] != trsc_pkg::QUAL_MAX) begin
                        qual_q[i] <= qual_q[i] + 1'b1;
                    end
                end else begin
                    edge_cnt_q[i] <= edge_cnt_q[i] + trsc_pkg::CNT_W'(rise[i]);
                end
            end
        end
    end
    // Activity loss disqualifies at once, without waiting for a window
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_valid_q <= '0;
        end else begin
            for (int i = 0; i < trsc_pkg::NUM_REF; i++) begin
                ref_valid_q[i] <= (act_cnt_q[i] != ACT_LIM) &&
                    (qual_q[i] == trsc_pkg::QUAL_MAX);
            end
        end
    end
    // Candidates from the two priority tables
    assign pri_cand = pick(ref_valid_q, pri_primary);
    assign sec_cand = pick(ref_valid_q, pri_secondary);
    // Primary selection; a slave copies the master's choice
    always_comb begin
        pri_sel_d = pri_cand[trsc_pkg::IDX_W-1:0];
        pri_sel_vld_d = pri_cand[trsc_pkg::IDX_W];
        if (slave_mode) begin
            pri_sel_d = msel_s2_q[trsc_pkg::IDX_W-1:0];
            pri_sel_vld_d = msel_s2_q[trsc_pkg::IDX_W];
        end else if (!revertive && pri_sel_vld_q && valid_pad[pri_sel_q]) begin
            pri_sel_d = pri_sel_q;
            pri_sel_vld_d = 1'b1;
        end
    end
    // Selection registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pri_sel_q <= '0;
            pri_sel_vld_q <= 1'b0;
            sec_sel_q <= '0;
            sec_sel_vld_q <= 1'b0;
        end else begin
            pri_sel_q <= pri_sel_d;
            pri_sel_vld_q <= pri_sel_vld_d;
            sec_sel_q <= sec_cand[trsc_pkg::IDX_W-1:0];
            sec_sel_vld_q <= sec_cand[trsc_pkg::IDX_W];
        end
    end
    // Primary loop state machine; a loss always passes through holdover
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= trsc_pkg::TRSC_FREE_RUN;
        end else begin
            case (state_q)
                trsc_pkg::TRSC_FREE_RUN: begin
                    if (pri_sel_vld_q && valid_pad[pri_sel_q]) begin
                        state_q <= trsc_pkg::TRSC_LOCKED;
                    end
                end
                trsc_pkg::TRSC_LOCKED: begin
                    if (!pri_sel_vld_q || !valid_pad[pri_sel_q]) begin
                        state_q <= trsc_pkg::TRSC_HOLDOVER;
                    end
                end
                trsc_pkg::TRSC_HOLDOVER: begin
                    // With nothing valid the loop never falls back to free-run
                    if (pri_sel_vld_q && valid_pad[pri_sel_q]) begin
                        state_q <= trsc_pkg::TRSC_LOCKED;
                    end
                end
                default: begin
                    state_q <= trsc_pkg::TRSC_FREE_RUN;
                end
            endcase
        end
    end
    // Long-term average kept only while locked
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_freq_q <= '0;
        end else if (state_q == trsc_pkg::TRSC_LOCKED) begin
            hold_freq_q <= hold_freq_q + trsc_pkg::FREQ_W'(($signed(primary_freq_in) -
                $signed(hold_freq_q)) >>> trsc_pkg::HOLD_SHIFT);
        end
    end
    // Output frequency offset; zero means master clock only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_freq_q <= '0;
        end else begin
            case (state_q)
                trsc_pkg::TRSC_LOCKED: out_freq_q <= primary_freq_in;
                trsc_pkg::TRSC_HOLDOVER: out_freq_q <= hold_freq_q;
                default: out_freq_q <= '0;
            endcase
        end
    end
    // Divide each loop's selected reference to an 8kHz pulse
    assign sel_rise[0] = rise_pad[pri_sel_q] & pri_sel_vld_q;
    assign sel_rise[1] = rise_pad[sec_sel_q] & sec_sel_vld_q;
    assign div_ratio[0] = div_primary;
    assign div_ratio[1] = div_secondary;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_q[0] <= '0;
            div_cnt_q[1] <= '0;
            pri_8k_q <= 1'b0;
            sec_8k_q <= 1'b0;
        end else begin
            for (int l = 0; l < 2; l++) begin
                // Ratio of zero or one passes each edge; 19440 covers 155.52MHz
                if (sel_rise[l] && div_cnt_q[l] + 1'b1 >= div_ratio[l]) begin
                    div_cnt_q[l] <= '0;
                end else if (sel_rise[l]) begin
                    div_cnt_q[l] <= div_cnt_q[l] + 1'b1;
                end
            end
            pri_8k_q <= sel_rise[0] && (div_cnt_q[0] + 1'b1 >= div_ratio[0]);
            sec_8k_q <= sel_rise[1] && (div_cnt_q[1] + 1'b1 >= div_ratio[1]);
        end
    end
    // Phase timer runs from an edge of one input to the next of another
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_run_q <= 1'b0;
            ph_cnt_q <= '0;
        end else if (!meas_phase_mode) begin
            ph_run_q <= 1'b0;
            ph_cnt_q <= '0;
        end else if (ph_run_q && rise_pad[meas_ref_b]) begin
            ph_run_q <= 1'b0;
        end else if (!ph_run_q && rise_pad[meas_ref_a]) begin
            ph_run_q <= 1'b1;
            ph_cnt_q <= '0;
        end else if (ph_run_q) begin
            ph_cnt_q <= ph_cnt_q + 1'b1;
        end
    end
    // Secondary loop measurement result
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_q <= '0;
            meas_vld_q <= 1'b0;
        end else if (meas_phase_mode) begin
            meas_vld_q <= ph_run_q && rise_pad[meas_ref_b];
            if (ph_run_q && rise_pad[meas_ref_b]) begin
                meas_q <= ph_cnt_q;
            end
        end else begin
            meas_vld_q <= gate_end && (meas_ref_a < trsc_pkg::IDX_W'(trsc_pkg::NUM_REF));
            if (gate_end && meas_ref_a < trsc_pkg::IDX_W'(trsc_pkg::NUM_REF)) begin
                meas_q <= edge_cnt_q[meas_ref_a];
            end
        end
    end
    // Oscillator watchdog; the flag drops again once edges return
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_cnt_q <= '0;
            osc_fail_q <= 1'b0;
        end else if (osc_rise) begin
            wdt_cnt_q <= '0;
            osc_fail_q <= 1'b0;
        end else if (wdt_cnt_q != WDT_LIM) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end else begin
            osc_fail_q <= 1'b1;
        end
    end
    // Master time advances sixteen master cycles per oscillator cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_time_q <= '0;
        end else if (osc_rise) begin
            master_time_q <= master_time_q + trsc_pkg::MTIME_W'(trsc_pkg::MCLK_MULT);
        end
    end
endmodule

// File: trsc_chk.sv
// Port-level assertions for the timing reference state control block
`timescale 1ns/100ps
module trsc_chk #(
    parameter int GATE_CYC = 100000,
    parameter int ACT_CYC = 25000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Watched inputs
    input wire logic [trsc_pkg::NUM_REF*trsc_pkg::PRI_W-1:0] pri_primary,
    input wire logic revertive,
    input wire logic [trsc_pkg::FREQ_W-1:0] primary_freq_in,
    input wire logic slave_mode,
    input wire logic local_osc_clock,
    // Watched outputs
    input wire logic [trsc_pkg::NUM_REF-1:0] ref_valid_q,
    input wire logic [trsc_pkg::IDX_W-1:0] pri_sel_q,
    input wire logic pri_sel_vld_q,
    input wire trsc_pkg::trsc_state_t state_q,
    input wire logic [trsc_pkg::FREQ_W-1:0] out_freq_q,
    input wire logic [trsc_pkg::FREQ_W-1:0] hold_freq_q,
    input wire logic pri_8k_q,
    input wire logic osc_fail_q,
    input wire logic [trsc_pkg::MTIME_W-1:0] master_time_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Idle time of the oscillator pin; the pin crosses two flops, so bounds keep slack
    logic osc_last_q;
    logic [7:0] idle_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_last_q <= 1'b0;
            idle_q <= 8'h00;
        end else begin
            osc_last_q <= local_osc_clock;
            if (local_osc_clock != osc_last_q) idle_q <= 8'h00;
            else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
        end
    end
    a_no_free_return: assert property (state_q != trsc_pkg::TRSC_FREE_RUN |=>
        state_q != trsc_pkg::TRSC_FREE_RUN) else $error("loop fell back to free-run");
    a_lock_needs_ref: assert property ((state_q != trsc_pkg::TRSC_LOCKED ##1
        state_q == trsc_pkg::TRSC_LOCKED) |-> $past(pri_sel_vld_q)) else $error("lock without ref");
    a_hold_frozen: assert property (state_q != trsc_pkg::TRSC_LOCKED |=>
        $stable(hold_freq_q)) else $error("holdover value moved outside lock");
    a_loss_holdover: assert property (state_q == trsc_pkg::TRSC_LOCKED && !slave_mode
        && pri_sel_vld_q && !ref_valid_q[pri_sel_q] |-> ##[1:2]
        state_q == trsc_pkg::TRSC_HOLDOVER) else $error("no holdover on loss");
    a_out_hold: assert property ($past(state_q) == trsc_pkg::TRSC_HOLDOVER |->
        out_freq_q == $past(hold_freq_q)) else $error("holdover output wrong");
    a_out_locked: assert property ($past(state_q) == trsc_pkg::TRSC_LOCKED |->
        out_freq_q == $past(primary_freq_in)) else $error("locked output wrong");
    a_out_free: assert property ($past(state_q) == trsc_pkg::TRSC_FREE_RUN |->
        out_freq_q == 32'h0) else $error("free-run output not nominal");
    a_nonrev_keep: assert property (!revertive && !slave_mode && pri_sel_vld_q
        && ref_valid_q[pri_sel_q] |=> pri_sel_q == $past(pri_sel_q)) else $error("sel moved");
    a_prio_zero: assert property (pri_sel_vld_q && !slave_mode && !$past(slave_mode) |->
        pri_primary[pri_sel_q*4+:4] != 4'h0) else $error("disabled input chosen");
    a_osc_flag: assert property (idle_q > 8'h1e |-> osc_fail_q)
        else $error("oscillator loss not flagged");
    a_osc_early: assert property ($rose(osc_fail_q) |-> idle_q >= 8'h12)
        else $error("oscillator flagged while running");
    a_mtime_step: assert property (master_time_q != $past(master_time_q) |->
        master_time_q == $past(master_time_q) + 32'h10) else $error("master time step");
    a_8k_pulse: assert property (pri_8k_q |=> !pri_8k_q)
        else $error("divided pulse too long");
endmodule
bind trsc_timing_ctrl trsc_chk #(.GATE_CYC(GATE_CYC), .ACT_CYC(ACT_CYC)) trsc_chk_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .pri_primary(pri_primary), .revertive(revertive),
    .primary_freq_in(primary_freq_in), .slave_mode(slave_mode),
    .local_osc_clock(local_osc_clock), .ref_valid_q(ref_valid_q), .pri_sel_q(pri_sel_q),
    .pri_sel_vld_q(pri_sel_vld_q), .state_q(state_q), .out_freq_q(out_freq_q),
    .hold_freq_q(hold_freq_q), .pri_8k_q(pri_8k_q), .osc_fail_q(osc_fail_q),
    .master_time_q(master_time_q));

// File: trsc_ref_model.sv
// Behavioural reference clock sources and local oscillator
`timescale 1ns/100ps
module trsc_ref_model (
    // Run controls from the bench
    input wire logic [trsc_pkg::NUM_REF-1:0] run,
    input wire logic osc_run,
    // Clock pins toward the block
    output logic [trsc_pkg::NUM_REF-1:0] ref_in,
    output logic local_osc_clock
);
    // Each source has its own half period so edges drift against ref_clk
    for (genvar i = 0; i < trsc_pkg::NUM_REF; i++) begin : g_src
        logic r;
        initial begin
            r = 1'b0;
            forever begin
                #(20 + 4 * i);
                if (run[i]) r = ~r; // A dead source sticks at its level
            end
        end
        assign ref_in[i] = r;
    end
    // Oscillator near 12.8MHz; the time grid rounds the half period slightly
    initial begin
        local_osc_clock = 1'b0;
        forever begin
            #39.0625;
            if (osc_run) local_osc_clock = ~local_osc_clock;
        end
    end
endmodule

// File: trsc_timing_ctrl_tb.sv
// Self-checking bench for the timing reference state control block
`timescale 1ns/100ps
module trsc_timing_ctrl_tb;
    localparam int GATE = 200;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [13:0] ref_in, run, ref_valid_q;
    logic osc_run, local_osc_clock, revertive, meas_phase_mode, slave_mode, master_vld;
    logic [335:0] exp_cnt;
    logic [23:0] freq_tol, meas_q;
    logic [55:0] pri_p, pri_s;
    logic [14:0] div_p, div_s;
    logic [31:0] freq_in, out_freq_q, hold_freq_q, master_time_q, t0;
    logic [3:0] meas_a, meas_b, master_sel, pri_sel_q, sec_sel_q;
    logic pri_sel_vld_q, sec_sel_vld_q, pri_8k_q, sec_8k_q, meas_vld_q, osc_fail_q;
    trsc_pkg::trsc_state_t state_q;
    int fail_count = 0;
    int n_checks = 0;
    int seed, n_p, n_s, e;
    trsc_timing_ctrl #(.GATE_CYC(GATE), .ACT_CYC(50)) trsc_timing_ctrl_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .ref_in(ref_in), .exp_cnt(exp_cnt),
        .freq_tol(freq_tol), .pri_primary(pri_p), .pri_secondary(pri_s),
        .revertive(revertive), .div_primary(div_p), .div_secondary(div_s),
        .primary_freq_in(freq_in), .meas_phase_mode(meas_phase_mode), .meas_ref_a(meas_a),
        .meas_ref_b(meas_b), .slave_mode(slave_mode), .master_sel_in(master_sel),
        .master_sel_vld_in(master_vld), .local_osc_clock(local_osc_clock),
        .ref_valid_q(ref_valid_q), .pri_sel_q(pri_sel_q), .pri_sel_vld_q(pri_sel_vld_q),
        .sec_sel_q(sec_sel_q), .sec_sel_vld_q(sec_sel_vld_q), .state_q(state_q),
        .out_freq_q(out_freq_q), .hold_freq_q(hold_freq_q), .pri_8k_q(pri_8k_q),
        .sec_8k_q(sec_8k_q), .meas_q(meas_q), .meas_vld_q(meas_vld_q),
        .osc_fail_q(osc_fail_q), .master_time_q(master_time_q));
    trsc_ref_model trsc_ref_model_i (.run(run), .osc_run(osc_run), .ref_in(ref_in),
        .local_osc_clock(local_osc_clock));
    // Clock and a fresh loop filter word every cycle
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) #1 freq_in = $urandom;
    // Rising edges of source i in one gate window
    function automatic logic [23:0] edges(input int i);
        return 24'(GATE * 10 / (40 + 8 * i));
    endfunction
    // Best enabled valid input; ties go to the lower index
    function automatic logic [4:0] best(input logic [13:0] v, input logic [55:0] t);
        logic [4:0] b;
        b = 5'h00;
        for (int i = 13; i >= 0; i--) begin
            if (v[i] && t[i*4+:4] != 4'h0 && (!b[4] || t[i*4+:4] <= t[b[3:0]*4+:4])) begin
                b = {1'b1, 4'(i)};
            end
        end
        return b;
    endfunction
    // Divided pulses in 640 cycles on selection s; ratio 0 or 1 passes every edge
    function automatic int rate(input logic [4:0] s, input logic [14:0] d);
        if (!s[4]) return 0;
        return 6400 / ((40 + 8 * s[3:0]) * (d > 15'h1 ? int'(d) : 1));
    endfunction
    function automatic logic hit(input int what);
        if (what == 2) return meas_vld_q === 1'b1;
        return state_q === (what == 0 ? trsc_pkg::TRSC_LOCKED : trsc_pkg::TRSC_HOLDOVER);
    endfunction
    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait: 0 locked, 1 holdover, 2 measurement ready
    task automatic wait_for(input int what, input int lim);
        for (int k = 0; k < lim && !hit(what); k++) cyc(1);
        if (!hit(what)) begin
            chk(32'(what), 32'hff, "wait timed out");
            print_verdict();
        end
    endtask
    initial begin
        seed = $urandom(32'h28875ca3);
        run = 14'h3fff;
        {osc_run, revertive} = 2'h3;
        {meas_phase_mode, slave_mode, master_vld} = 3'h0;
        {freq_tol, meas_a, meas_b, master_sel} = {24'h2, 4'h0, 4'hf, 4'h0};
        // Random tables with a fixed best pair; input 5 disabled, input 13 mis-set
        for (int i = 0; i < 14; i++) begin
            exp_cnt[i*24+:24] = edges(i) + (i == 13 ? 24'ha : 24'h0);
            pri_p[i*4+:4] = 4'($urandom_range(15, 3));
            pri_s[i*4+:4] = 4'($urandom_range(15, 0));
        end
        {pri_p[23:20], pri_p[15:12], pri_p[31:28]} = 12'h012;
        div_p = 15'($urandom_range(8, 1));
        div_s = 15'($urandom_range(8, 0));
        cyc(2);
        reset_n = 1'b1;
        chk(state_q, trsc_pkg::TRSC_FREE_RUN, "start state");
        wait_for(0, 1500);
        cyc(2);
        chk(ref_valid_q, 14'h1fff, "valid mask");
        chk({pri_sel_vld_q, pri_sel_q}, best(14'h1fff, pri_p), "primary sel");
        chk({sec_sel_vld_q, sec_sel_q}, best(14'h1fff, pri_s), "secondary sel");
        wait_for(2, 400);
        chk(32'((meas_q + 24'h2 - edges(0)) <= 24'h4), 32'h1, "freq count");
        // Phase mode with both ends on one input gives its period less one cycle
        meas_a = 4'($urandom_range(12, 0));
        meas_b = meas_a;
        meas_phase_mode = 1'b1;
        cyc(1);
        wait_for(2, 40);
        e = (30 + 8 * meas_a) / 10;
        chk(32'($unsigned(int'(meas_q) + 1 - e) <= 2), 32'h1, "phase count");
        meas_phase_mode = 1'b0;
        // Lose the selected source: holdover, then the next best
        run[3] = 1'b0;
        wait_for(1, 120);
        wait_for(0, 10);
        chk({pri_sel_vld_q, pri_sel_q}, best(14'h1ff7, pri_p), "next sel");
        // Restored better source is ignored until switching is revertive
        revertive = 1'b0;
        run[3] = 1'b1;
        cyc(1000);
        chk(ref_valid_q[3], 1'b1, "restored valid");
        chk(pri_sel_q, 4'h7, "nonrevertive sel");
        revertive = 1'b1;
        cyc(3);
        chk(pri_sel_q, 4'h3, "revertive sel");
        chk(state_q, trsc_pkg::TRSC_LOCKED, "hitless");
        // Count divided pulses over 640 cycles on the settled selections
        {n_p, n_s} = 64'h0;
        repeat (640) begin
            cyc(1);
            n_p += int'(pri_8k_q);
            n_s += int'(sec_8k_q);
        end
        e = rate(5'h13, div_p);
        chk(32'($unsigned(n_p + 2 - e) <= 4), 32'h1, "primary 8k rate");
        e = rate(best(14'h1fff, pri_s), div_s);
        chk(32'($unsigned(n_s + 2 - e) <= 4), 32'h1, "secondary 8k rate");
        // Every source lost
        run = 14'h0;
        wait_for(1, 120);
        cyc(300);
        chk(state_q, trsc_pkg::TRSC_HOLDOVER, "stay holdover");
        chk(ref_valid_q, 14'h0, "none valid");
        // Oscillator stops and returns; master time counts in sixteens
        osc_run = 1'b0;
        cyc(40);
        chk(osc_fail_q, 1'b1, "osc fail");
        osc_run = 1'b1;
        cyc(20);
        chk(osc_fail_q, 1'b0, "osc ok");
        t0 = master_time_q;
        cyc(100);
        chk(32'((master_time_q - t0 - 32'hc0) <= 32'h20), 32'h1, "master rate");
        // Slave follows the master's choice
        run = 14'h3fff;
        {slave_mode, master_vld, master_sel} = {2'h3, 4'h5};
        cyc(8);
        chk({pri_sel_vld_q, pri_sel_q}, 5'h15, "slave sel");
        reset_n = 1'b0;
        cyc(2);
        chk(state_q, trsc_pkg::TRSC_FREE_RUN, "reset state");
        print_verdict();
    end
endmodule
